/* File: common/rsp_consts.vh */
// constants for the rtc serial register port
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH
`define RSP_FIFO_DEPTH      16
`define RSP_FIFO_AW         4
`define RSP_DATA_W          8
`define RSP_NUM_REGS        32
`define RSP_ADDR_MASK       6'h1F
`define RSP_ADDR_CENT_HOUR  5'h03
`define RSP_ADDR_TIME_LAST  5'h07
`define RSP_ADDR_SQW        5'h13
`define RSP_ADDR_USER0      5'h19
`define RSP_SQW_RESET       8'h10
`define RSP_SUBSEC_DIV      9'd328
`define RSP_SQW_SEL_LSB     4
`endif

/* File: testbench/rsp_master.sv */
// mode 0 serial master model facing the register port
`timescale 1ns/10ps
`default_nettype none
module rsp_master (
  // clock
  input wire logic clk,
  // serial link
  output logic     sel_n,
  output logic     sclk,
  output logic     serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  initial
  begin
    sel_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end
  task start;
    @(negedge clk);
    sel_n = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  // released data line shows the inverse of its last bit
  task stop;
    repeat (8) @(negedge clk);
    sel_n = 1'b1;
    serial_in = ~serial_in;
    repeat (8) @(negedge clk);
  endtask
  task xbyte(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i--)
    begin
      serial_in = tx[i];
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      rx[i] = serial_out_oe_n ? 1'bz : serial_out;
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
endmodule // rsp_master
`default_nettype wire

/* File: testbench/rsp_port_sva.sv */
// assertion checker for the serial register port
`timescale 1ns/10ps
`default_nettype none
module rsp_port_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // serial link
  input wire logic       sel_n,
  input wire logic       sclk,
  input wire logic       serial_in,
  input wire logic       serial_out,
  input wire logic       serial_out_oe_n,
  // oscillator and byte stream
  input wire logic       osc_32k,
  input wire logic       square_wave_out,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_data
);
  logic       sclk_ff;
  logic [6:0] cnt_ff;
  logic       wr_ff;
  wire        rise = sclk && !sclk_ff && !sel_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // raw pin bit count; pins move only at falling clk, so sampling is clean
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_ff <= 1'b0;
      cnt_ff  <= 7'h00;
      wr_ff   <= 1'b0;
    end
    else
    begin
      sclk_ff <= sclk;
      if (sel_n)
        cnt_ff <= 7'h00;
      else if (rise)
        cnt_ff <= cnt_ff + 7'h01;
      if (rise && cnt_ff == 7'h00)
        wr_ff <= serial_in;
    end
  end
  a_desel_hiz: assert property (sel_n [*6] |-> serial_out_oe_n)
    else $error("output driven while deselected");
  a_oe_release: assert property ($rose(sel_n) |-> ##[1:6] serial_out_oe_n)
    else $error("output not released after deselect");
  a_header_hiz: assert property (!sel_n && cnt_ff < 7'h08 |-> serial_out_oe_n)
    else $error("output driven during header");
  a_write_hiz: assert property (!sel_n && wr_ff && cnt_ff != 7'h00 |-> serial_out_oe_n)
    else $error("output driven during write");
  a_read_drive: assert property ($fell(sclk) && !sel_n && cnt_ff == 7'h08 && !wr_ff
    |-> ##[1:6] !serial_out_oe_n)
    else $error("read byte not driven");
  a_shift_fall: assert property (!serial_out_oe_n && $past(!serial_out_oe_n)
    && $changed(serial_out) |-> !sclk)
    else $error("output changed while clock high");
  a_byte_push: assert property (rise && wr_ff && cnt_ff[2:0] == 3'h7 && cnt_ff > 7'h08
    |-> ##[1:10] wr_valid)
    else $error("written byte not pushed");
  a_valid_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("stream byte dropped while stalled");
  c_write: cover property ($rose(wr_valid));
  c_read: cover property ($fell(serial_out_oe_n));
  c_burst: cover property (rise && cnt_ff == 7'h40);
endmodule // rsp_port_sva
bind rsp_port rsp_port_sva chk (.clk, .nrst, .sel_n, .sclk, .serial_in, .serial_out,
  .serial_out_oe_n, .osc_32k, .square_wave_out, .wr_valid, .wr_ready, .wr_data);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the serial register port
`timescale 1ns/10ps
`default_nettype none
`include "rsp_consts.vh"
module testbench;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       osc_32k = 1'b0;
  logic       wr_ready = 1'b0;
  wire        sel_n, sclk, serial_in, serial_out, serial_out_oe_n;
  wire        square_wave_out, wr_valid;
  wire  [7:0] wr_data;
  logic [7:0] d [0:6];
  logic [7:0] rx;
  int         num_errors = 0;
  int         n_tests = 0;
  always #5 clk = ~clk;
  // oscillator unrelated in phase to clk
  always #15259 osc_32k = ~osc_32k;
  rsp_port dut (.clk, .nrst, .sel_n, .sclk, .serial_in, .serial_out, .serial_out_oe_n,
    .osc_32k, .square_wave_out, .wr_valid, .wr_ready, .wr_data);
  rsp_master mst (.clk, .sel_n, .sclk, .serial_in, .serial_out, .serial_out_oe_n);
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task conclude;
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // user bytes, then calendar bytes at their reset values after the wrap
  function logic [7:0] exp_rd(input int i);
    return i < 7 ? d[i] : (i == 11 ? 8'h01 : 8'h00);
  endfunction
  // bounded wait for a stream byte
  task wait_valid;
    int k;
    for (k = 0; k < 100 && wr_valid !== 1'b1; k++)
      @(negedge clk);
    if (wr_valid !== 1'b1)
    begin
      num_errors++;
      conclude;
    end
  endtask
  initial
  begin
    int r;
    int i;
    void'($urandom(32'hECC5));
    repeat (3) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    // stray clocks before any select fall
    mst.xbyte(8'h9A, rx);
    repeat (8) @(negedge clk);
    check({7'h00, wr_valid}, 8'h00);
    check({7'h00, serial_out_oe_n}, 8'h01);
    for (r = 0; r < 2; r++)
    begin
      for (i = 0; i < 7; i++)
        d[i] = 8'($urandom);
      if (r == 0)
      begin
        d[0] = 8'h80;
        d[6] = 8'h01;
      end
      // burst write with the stream side stalled
      mst.start;
      mst.xbyte(8'h80 | {3'h0, `RSP_ADDR_USER0}, rx);
      for (i = 0; i < 7; i++)
        mst.xbyte(d[i], rx);
      mst.stop;
      for (i = 0; i < 7; i++)
      begin
        wait_valid;
        check(wr_data, d[i]);
        wr_ready = 1'b1;
        @(negedge clk);
        wr_ready = 1'b0;
        @(negedge clk);
      end
      // burst read, ignored address bit set, wrapping past the top
      mst.start;
      mst.xbyte(8'h40 | {3'h0, `RSP_ADDR_USER0}, rx);
      for (i = 0; i < 12; i++)
      begin
        mst.xbyte(8'h00, rx);
        check(rx, exp_rd(i));
      end
      mst.stop;
    end
    // minute byte written through the frozen copy reaches the counters at deselect
    mst.start;
    mst.xbyte(8'h82, rx);
    mst.xbyte(8'h37, rx);
    mst.stop;
    wait_valid;
    check(wr_data, 8'h37);
    wr_ready = 1'b1;
    @(negedge clk);
    wr_ready = 1'b0;
    @(negedge clk);
    mst.start;
    mst.xbyte(8'h02, rx);
    mst.xbyte(8'h00, rx);
    check(rx, 8'h37);
    mst.stop;
    // square wave follows the oscillator after reset
    r = osc_32k;
    for (i = 0; i < 2000 && osc_32k == r; i++)
      @(negedge clk);
    if (i == 2000)
      num_errors++;
    repeat (10) @(negedge clk);
    check({7'h00, square_wave_out}, {7'h00, osc_32k});
    conclude;
  end
endmodule // testbench
`default_nettype wire

/* File: verilog/rsp_fifo.v */
// parameterised valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module rsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             nrst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ff;
  reg [AW:0]      rd_ff;
  wire            full;
  wire            empty;

  // extra pointer bit separates full from empty
  assign empty     = (wr_ff == rd_ff);
  assign full      = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ff[AW-1:0]];

  // storage write
  always @(posedge clk)
  begin
    if (in_valid && !full)
      mem[wr_ff[AW-1:0]] <= in_data;
  end

  // pointers
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
        wr_ff <= wr_ff + 1'b1;
      if (out_ready && !empty)
        rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule // rsp_fifo
`default_nettype wire

/* File: verilog/rsp_port.v */
// serial register port of a real-time clock with calendar counters
`timescale 1ns/10ps
`default_nettype none
`include "rsp_consts.vh"
// How it works
// - address pointer steps by one after every data byte, read or write
// - 32 bytes: 8 calendar, 17 status/control, 7 user storage
// - calendar fields held as bcd, hours in 24-hour form
// - date rolls over at 28, 29, 30 or 31 days automatically
// - while deselected, serial clock and input ignored, output high impedance
// - output high impedance until a full read byte is ready; always during write
// - serial input sampled on rising serial clock edges while selected
// - serial output changes after each falling serial clock edge during read
// - no operation until a falling edge of select seen after power-up
// - direction, address and write data all arrive on serial input
// - square wave output defaults to the 32 khz rate at power-up
// - first bit one writes, zero reads; seven address bits, bits 6 and 5 ignored
// - address and data shift most significant bit first
// - burst pointer wraps from top address back to zero
// - time counters copied to holding registers at each transfer start
module rsp_port (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // serial link pins
  input  wire       sel_n,
  input  wire       sclk,
  input  wire       serial_in,
  output reg        serial_out,
  output reg        serial_out_oe_n,
  // oscillator and square wave
  input  wire       osc_32k,
  output wire       square_wave_out,
  // written byte stream
  output wire       wr_valid,
  input  wire       wr_ready,
  output wire [7:0] wr_data
);
  // synchronisers, first stage read only by second
  reg [1:0] s1_ff;
  reg [1:0] s2_ff;
  reg [1:0] s3_ff;
  reg [1:0] s4_ff;
  reg       sel_d_ff;
  reg       sclk_d_ff;
  reg       osc_d_ff;
  wire      sel_s  = s1_ff[1];
  wire      sclk_s = s2_ff[1];
  wire      sdi_s  = s3_ff[1];
  wire      osc_s  = s4_ff[1];
  wire      sel_fall  = sel_d_ff & ~sel_s;
  wire      sel_rise  = ~sel_d_ff & sel_s;
  wire      sclk_rise = ~sclk_d_ff & sclk_s;
  wire      sclk_fall = sclk_d_ff & ~sclk_s;
  wire      osc_rise  = ~osc_d_ff & osc_s;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_ff     <= 2'h3;
      s2_ff     <= 2'h0;
      s3_ff     <= 2'h0;
      s4_ff     <= 2'h0;
      sel_d_ff  <= 1'b1;
      sclk_d_ff <= 1'b0;
      osc_d_ff  <= 1'b0;
    end
    else
    begin
      s1_ff     <= {s1_ff[0], sel_n};
      s2_ff     <= {s2_ff[0], sclk};
      s3_ff     <= {s3_ff[0], serial_in};
      s4_ff     <= {s4_ff[0], osc_32k};
      sel_d_ff  <= sel_s;
      sclk_d_ff <= sclk_s;
      osc_d_ff  <= osc_s;
    end
  end

  // register space, index 0..31
  // 32-byte register map
  reg  [7:0] regs [0:`RSP_NUM_REGS-1];
  reg  [7:0] hold [0:7];
  reg        armed_ff;
  reg        active_ff;
  reg        write_ff;
  reg        hdr_done_ff;
  reg  [2:0] bit_ff;
  reg  [7:0] shift_ff;
  reg  [5:0] ptr_ff;
  reg  [7:0] out_ff;
  reg        rd_live_ff;
  reg        time_dirty_ff;
  reg        push_ff;
  reg  [7:0] push_data_ff;
  wire [7:0] nxt_shift = {shift_ff[6:0], sdi_s};
  wire [5:0] ptr_m = ptr_ff & `RSP_ADDR_MASK;
  wire [4:0] idx = ptr_m[4:0];
  wire [4:0] nxt_idx = nxt_shift[4:0];
  // read source: frozen copy for time bytes
  wire [7:0] rd_byte = (idx <= `RSP_ADDR_TIME_LAST) ? hold[idx[2:0]] : regs[idx];
  wire [7:0] hd_byte = (nxt_idx <= `RSP_ADDR_TIME_LAST) ? hold[nxt_idx[2:0]] : regs[nxt_idx];
  wire       fifo_in_ready;
  // hold the push only while the fifo is full, so each byte enters once
  wire       stall = push_ff & ~fifo_in_ready;
  wire       tick;

  rsp_fifo #(
    .WIDTH (`RSP_DATA_W),
    .DEPTH (`RSP_FIFO_DEPTH),
    .AW    (`RSP_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_ff),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  // bcd counter helpers
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    end
  endfunction
  // month length with leap years from year bcd
  // limitation: century bits are not consulted, every year 00 counts as leap
  function [7:0] month_len;
    input [7:0] mon;
    input [7:0] yr;
    reg         leap;
    begin
      // bcd year divisible by four: even tens need units 0/4/8, odd tens 2/6
      if (yr[4] == 1'b0)
        leap = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
      else
        leap = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
      if (mon == 8'h02)
        month_len = leap ? 8'h29 : 8'h28;
      else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
        month_len = 8'h30;
      else
        month_len = 8'h31;
    end
  endfunction
  // next hour value, only the low six bits are hours
  wire [7:0] hr_inc = bcd_inc({2'h0, regs[3][5:0]});

  // hundredths tick from 32 khz edges, 328 edges approximates 10 ms
  reg [8:0] div_ff;
  assign tick = osc_rise && (div_ff == `RSP_SUBSEC_DIV - 9'd1);
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_ff <= 9'h000;
    else if (osc_rise)
      div_ff <= tick ? 9'h000 : div_ff + 9'h001;
  end

  // square wave, rate select in upper nibble of its register
  // 32 khz default
  assign square_wave_out = (regs[`RSP_ADDR_SQW][7:`RSP_SQW_SEL_LSB] == 4'h1) ? osc_s : 1'b0;

  // serial engine and counters
  integer i;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      armed_ff        <= 1'b0;
      active_ff       <= 1'b0;
      write_ff        <= 1'b0;
      hdr_done_ff     <= 1'b0;
      bit_ff          <= 3'h0;
      shift_ff        <= 8'h00;
      ptr_ff          <= 6'h00;
      out_ff          <= 8'h00;
      rd_live_ff      <= 1'b0;
      time_dirty_ff   <= 1'b0;
      push_ff         <= 1'b0;
      push_data_ff    <= 8'h00;
      serial_out      <= 1'b0;
      serial_out_oe_n <= 1'b1;
      for (i = 0; i < `RSP_NUM_REGS; i = i + 1)
        regs[i] <= 8'h00;
      regs[`RSP_ADDR_SQW] <= `RSP_SQW_RESET;
      regs[5] <= 8'h01;
      regs[6] <= 8'h01;
      regs[4] <= 8'h01;
      for (i = 0; i < 8; i = i + 1)
        hold[i] <= 8'h00;
    end
    else
    begin
      if (!stall)
        push_ff <= 1'b0;
      if (tick)
      begin
        regs[0] <= (regs[0] == 8'h99) ? 8'h00 : bcd_inc(regs[0]);
        if (regs[0] == 8'h99)
        begin
          regs[1] <= (regs[1] == 8'h59) ? 8'h00 : bcd_inc(regs[1]);
          if (regs[1] == 8'h59)
          begin
            regs[2] <= (regs[2] == 8'h59) ? 8'h00 : bcd_inc(regs[2]);
            if (regs[2] == 8'h59)
            begin
              regs[3][5:0] <= (regs[3][5:0] == 6'h23) ? 6'h00 : hr_inc[5:0];
              if (regs[3][5:0] == 6'h23)
              begin
                regs[4] <= (regs[4] == 8'h07) ? 8'h01 : regs[4] + 8'h01;
                if (regs[5] == month_len(regs[6], regs[7]))
                begin
                  regs[5] <= 8'h01;
                  regs[6] <= (regs[6] == 8'h12) ? 8'h01 : bcd_inc(regs[6]);
                  if (regs[6] == 8'h12)
                  begin
                    regs[7] <= (regs[7] == 8'h99) ? 8'h00 : bcd_inc(regs[7]);
                    if (regs[7] == 8'h99)
                      regs[3][7:6] <= regs[3][7:6] + 2'h1;
                  end
                end
                else
                  regs[5] <= bcd_inc(regs[5]);
              end
            end
          end
        end
      end
      if (sel_s)
      begin
        active_ff       <= 1'b0;
        rd_live_ff      <= 1'b0;
        serial_out_oe_n <= 1'b1;
      end
      // arm only on a select falling edge
      if (sel_fall)
      begin
        armed_ff    <= 1'b1;
        active_ff   <= 1'b1;
        hdr_done_ff <= 1'b0;
        bit_ff      <= 3'h0;
        time_dirty_ff <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
          hold[i] <= regs[i];
      end
      if (sel_rise && time_dirty_ff)
      begin
        for (i = 0; i < 8; i = i + 1)
          regs[i] <= hold[i];
        time_dirty_ff <= 1'b0;
      end
      if (active_ff && armed_ff && !sel_s && sclk_rise)
      begin
        // all fields on serial input; msb first
        shift_ff <= nxt_shift;
        bit_ff   <= bit_ff + 3'h1;
        if (bit_ff == 3'h7)
        begin
          if (!hdr_done_ff)
          begin
            // direction bit then address, bits 6 and 5 ignored
            hdr_done_ff <= 1'b1;
            write_ff    <= nxt_shift[7];
            ptr_ff      <= {1'b0, nxt_shift[4:0]};
            out_ff      <= hd_byte;
            rd_live_ff  <= ~nxt_shift[7];
          end
          else
          begin
            if (write_ff)
            begin
              if (idx <= `RSP_ADDR_TIME_LAST)
              begin
                hold[idx[2:0]] <= nxt_shift;
                time_dirty_ff  <= 1'b1;
              end
              else
                regs[idx] <= nxt_shift;
              push_ff      <= 1'b1;
              push_data_ff <= nxt_shift;
            end
            // pointer step; wrap at top to zero
            ptr_ff <= ptr_ff + 6'h01;
          end
        end
      end
      // output changes after falling edge; driven only on read byte
      if (active_ff && !sel_s && sclk_fall && rd_live_ff)
      begin
        serial_out_oe_n <= 1'b0;
        serial_out      <= out_ff[7];
        if (bit_ff == 3'h0)
          out_ff <= rd_byte;
        else
          out_ff <= {out_ff[6:0], 1'b0};
      end
      // reload next byte once a data byte completes
      if (active_ff && !sel_s && sclk_fall && rd_live_ff && bit_ff == 3'h0 && hdr_done_ff)
        serial_out <= rd_byte[7];
      if (active_ff && !sel_s && sclk_fall && rd_live_ff && bit_ff == 3'h0)
        out_ff <= {rd_byte[6:0], 1'b0};
    end
  end
endmodule // rsp_port
`default_nettype wire
